// ==== rtl/packetizer_regs.svh ====
// Timing counts and limits of the serial packetizer
`ifndef PACKETIZER_REGS_SVH
`define PACKETIZER_REGS_SVH
`define CLK_FREQ_HZ 10000000
`define MIN_IDLE_TIME_NS 100000
`define MIN_IDLE_CYCLES ((`MIN_IDLE_TIME_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define MAX_PACKET_BYTES 16'h0400
`define BUF_DEPTH 2048
`define BUF_AW 11
`define CMD_CHAR_RESET 8'h2B
`define CMD_SEQ_LEN 2'h3
`define GUARD_MS_RESET 16'h03E8
`define CYCLES_PER_MS 14'h2710
`endif

// ==== rtl/packetizer_pkg.sv ====
// Types shared by the serial packetizer
package packetizer_pkg;
  typedef enum {MODE_IDLE, MODE_TX_FLUSH, MODE_RX, MODE_CMD} op_mode_t;
  typedef enum {GS_WAIT_PRE, GS_CHARS, GS_WAIT_POST} guard_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } byte_beat_t;
  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic [31:0] addr;
    logic valid;
  } rf_beat_t;
endpackage : packetizer_pkg

// ==== rtl/serial_packetizer_mode_control.sv ====
// Serial packetizer and operating-mode controller
// Function
// (RQ1) Transparent mode queues every serial byte for RF unless in command mode; bytes arriving while the buffer is full are dropped and set overflow.
// (RQ2) Transparent mode sends each received RF payload out the UART; RF bytes arriving in MODE_TX_FLUSH or MODE_CMD are dropped.
// (RQ3) SPI never offers transparent mode; its traffic is always framed.
// (RQ4) Idle count zero packetizes buffered data at once.
// (RQ5) Non-zero idle count packetizes after that many quiet character times.
// (RQ6) The packetizing idle period never lasts less than 100 microseconds.
// (RQ7) On the command sequence, flush buffered bytes first, then enter command mode.
// (RQ8) Packetize once the buffer holds one full RF packet.
// (RQ9) In API mode every serial byte travels inside a frame.
// (RQ10) Host sends transmit, local command and remote command frames.
// (RQ11) Device emits receive, response, sample and event frames.
// (RQ12) Each API transmit request may get a transmit status frame.
// (RQ13) Every received-data frame carries the sender's source address.
// (RQ14) Stay idle unless transmitting, receiving, sleeping or in command mode.
// (RQ15) Each packet goes to the configured destination address.
// (RQ16) A valid RF packet moves into the serial transmit buffer.
// (RQ17) Command mode routes serial characters to the command parser.
// (RQ18) Command mode is unavailable on SPI; SPI configures only by frames.
// (RQ19) Host enters command mode by guard silence, three characters, guard silence.
// (RQ20) SPI always behaves as if API mode were selected.
// (RQ21) One character time is a full serial frame at the configured rate.
`timescale 1ns/1ns
`include "packetizer_regs.svh"
module serial_packetizer_mode_control (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration
  input wire logic spi_port_select,
  input wire logic api_mode_select,
  input wire logic [7:0] idle_packetize_char_count,
  input wire logic [15:0] char_time_cycles,
  input wire logic [15:0] guard_silence_time,
  input wire logic [7:0] command_sequence_char,
  input wire logic [31:0] dest_addr,
  input wire logic cmd_exit,
  // Serial line activity pin
  input wire logic serial_din_pin,
  // Received serial bytes from the port deserializer
  input wire packetizer_pkg::byte_beat_t ser_rx,
  // Bytes toward RF transmit, frame parser or command parser
  output packetizer_pkg::rf_beat_t rf_tx,
  input wire logic rf_tx_ready,
  output packetizer_pkg::byte_beat_t api_rx,
  output packetizer_pkg::byte_beat_t cmd_rx,
  // Received RF data
  input wire packetizer_pkg::byte_beat_t rf_rx,
  input wire logic rf_rx_last,
  input wire logic [31:0] rf_rx_src_addr,
  output packetizer_pkg::byte_beat_t ser_tx,
  output logic [31:0] ser_tx_src_addr,
  output logic ser_tx_framed,
  // Status
  output packetizer_pkg::op_mode_t op_mode,
  output logic overflow
);
  ////////////////////////////////////////////////////////////////////////////
  // Input synchronizer and line-activity timers
  logic din_meta, din_sync, din_last;
  logic [7:0] buf_mem [0:`BUF_DEPTH-1];
  logic [`BUF_AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [15:0] count, next_count;
  logic [15:0] char_cnt, next_char_cnt;
  logic [7:0] idle_chars, next_idle_chars;
  logic [15:0] min_cnt, next_min_cnt;
  logic [13:0] ms_cnt, next_ms_cnt;
  logic [15:0] quiet_ms, next_quiet_ms;
  logic [15:0] seq_ms, next_seq_ms;
  logic [1:0] plus_cnt, next_plus_cnt;
  logic cmd_pending, next_cmd_pending;
  logic flushing, next_flushing;
  packetizer_pkg::guard_state_t gstate, next_gstate;
  packetizer_pkg::op_mode_t next_op_mode;
  packetizer_pkg::rf_beat_t next_rf_tx;
  packetizer_pkg::byte_beat_t next_api_rx, next_cmd_rx, next_ser_tx;
  logic [31:0] next_src;
  logic next_framed, next_overflow;
  logic transparent, line_edge, idle_done, guard_ok, push, pop, full, seq_done, rx_take;

  always_ff @(posedge clk) begin
    din_meta <= serial_din_pin;
    din_sync <= din_meta;
    din_last <= din_sync;
  end

  // SPI forces framed traffic regardless of the select  // see (RQ3)
  assign transparent = !api_mode_select && !spi_port_select; // see (RQ20)
  assign line_edge = din_sync != din_last;
  assign full = count == 16'(`BUF_DEPTH);
  assign idle_done = (idle_chars >= idle_packetize_char_count) && (min_cnt == 16'h0000);
  assign guard_ok = quiet_ms >= guard_silence_time;

  ////////////////////////////////////////////////////////////////////////////
  // Idle timing
  always_comb begin
    next_char_cnt = char_cnt;
    next_idle_chars = idle_chars;
    next_min_cnt = min_cnt;
    next_ms_cnt = ms_cnt;
    next_quiet_ms = quiet_ms;
    if (line_edge || ser_rx.valid) begin
      // Character time spans start, data, parity and stop bits  // see (RQ21)
      next_char_cnt = 16'h0000;
      next_idle_chars = 8'h00;
      next_min_cnt = 16'(`MIN_IDLE_CYCLES); // see (RQ6)
      next_ms_cnt = 14'h0000;
      next_quiet_ms = 16'h0000;
    end else begin
      if (min_cnt != 16'h0000)
        next_min_cnt = min_cnt - 16'h0001;
      if (char_cnt + 16'h0001 >= char_time_cycles) begin
        next_char_cnt = 16'h0000;
        if (idle_chars != 8'hFF)
          next_idle_chars = idle_chars + 8'h01; // see (RQ5)
      end else begin
        next_char_cnt = char_cnt + 16'h0001;
      end
      if (ms_cnt == `CYCLES_PER_MS - 14'h0001) begin
        next_ms_cnt = 14'h0000;
        if (quiet_ms != 16'hFFFF)
          next_quiet_ms = quiet_ms + 16'h0001;
      end else begin
        next_ms_cnt = ms_cnt + 14'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      char_cnt <= 16'h0000;
      idle_chars <= 8'h00;
      min_cnt <= 16'h0000;
      ms_cnt <= 14'h0000;
      quiet_ms <= 16'h0000;
    end else begin
      char_cnt <= next_char_cnt;
      idle_chars <= next_idle_chars;
      min_cnt <= next_min_cnt;
      ms_cnt <= next_ms_cnt;
      quiet_ms <= next_quiet_ms;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequence detector
  always_comb begin
    next_gstate = gstate;
    next_plus_cnt = plus_cnt;
    next_seq_ms = seq_ms;
    seq_done = 1'b0;
    unique case (gstate)
      packetizer_pkg::GS_WAIT_PRE: begin
        if (ser_rx.valid && ser_rx.data == command_sequence_char && guard_ok) begin
          next_gstate = packetizer_pkg::GS_CHARS;
          next_plus_cnt = 2'h1;
          next_seq_ms = 16'h0000;
        end
      end
      packetizer_pkg::GS_CHARS: begin
        if (ms_cnt == `CYCLES_PER_MS - 14'h0001)
          next_seq_ms = seq_ms + 16'h0001;
        if (seq_ms >= guard_silence_time)
          next_gstate = packetizer_pkg::GS_WAIT_PRE;
        else if (ser_rx.valid) begin
          if (ser_rx.data != command_sequence_char)
            next_gstate = packetizer_pkg::GS_WAIT_PRE;
          else if (plus_cnt + 2'h1 == `CMD_SEQ_LEN)
            next_gstate = packetizer_pkg::GS_WAIT_POST;
          else
            next_plus_cnt = plus_cnt + 2'h1;
        end
      end
      packetizer_pkg::GS_WAIT_POST: begin
        if (ser_rx.valid)
          next_gstate = packetizer_pkg::GS_WAIT_PRE;
        else if (guard_ok) begin
          seq_done = 1'b1; // see (RQ19)
          next_gstate = packetizer_pkg::GS_WAIT_PRE;
        end
      end
    endcase
    if (!transparent || op_mode == packetizer_pkg::MODE_CMD)
      next_gstate = packetizer_pkg::GS_WAIT_PRE; // see (RQ18)
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gstate <= packetizer_pkg::GS_WAIT_PRE;
      plus_cnt <= 2'h0;
      seq_ms <= 16'h0000;
    end else begin
      gstate <= next_gstate;
      plus_cnt <= next_plus_cnt;
      seq_ms <= next_seq_ms;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial receive buffer, mode control and routing
  always_comb begin
    push = transparent && ser_rx.valid && op_mode != packetizer_pkg::MODE_CMD; // see (RQ1)
    pop = flushing && count != 16'h0000 && rf_tx_ready;
    rx_take = 1'b0;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_overflow = overflow;
    if (push && full)
      next_overflow = 1'b1;
    if (push && !full)
      next_wr_ptr = wr_ptr + `BUF_AW'(1);
    if (pop)
      next_rd_ptr = rd_ptr + `BUF_AW'(1);
    next_count = count + 16'(push && !full) - 16'(pop);
    next_rf_tx = '0;
    next_rf_tx.valid = pop;
    next_rf_tx.data = buf_mem[rd_ptr];
    next_rf_tx.addr = dest_addr; // see (RQ15)
    next_rf_tx.last = pop && count == 16'h0001;
    next_cmd_pending = cmd_pending || seq_done;
    next_flushing = flushing;
    next_op_mode = op_mode;
    unique case (op_mode)
      packetizer_pkg::MODE_IDLE: begin
        if (seq_done || cmd_pending) begin
          if (count != 16'h0000)
            next_flushing = 1'b1; // see (RQ7)
          else begin
            next_op_mode = packetizer_pkg::MODE_CMD;
            next_cmd_pending = 1'b0;
          end
        end else if (rf_rx.valid) begin
          // First byte of a packet is forwarded too; a lone last byte stays idle
          rx_take = 1'b1;
          if (!rf_rx_last)
            next_op_mode = packetizer_pkg::MODE_RX; // see (RQ14)
        end else if (count != 16'h0000 && (idle_packetize_char_count == 8'h00 // see (RQ4)
                 || idle_done || count >= `MAX_PACKET_BYTES)) // see (RQ8)
          next_flushing = 1'b1;
        if (next_flushing)
          next_op_mode = packetizer_pkg::MODE_TX_FLUSH;
      end
      packetizer_pkg::MODE_TX_FLUSH: begin
        if (pop && count == 16'h0001) begin
          next_flushing = 1'b0;
          next_op_mode = packetizer_pkg::MODE_IDLE;
        end
      end
      packetizer_pkg::MODE_RX: begin
        if (rf_rx.valid && rf_rx_last)
          next_op_mode = packetizer_pkg::MODE_IDLE;
      end
      packetizer_pkg::MODE_CMD: begin
        if (cmd_exit)
          next_op_mode = packetizer_pkg::MODE_IDLE;
      end
    endcase
    next_cmd_rx.valid = ser_rx.valid && op_mode == packetizer_pkg::MODE_CMD; // see (RQ17)
    next_cmd_rx.data = ser_rx.data;
    next_api_rx.valid = ser_rx.valid && !transparent; // see (RQ9), see (RQ12)
    next_api_rx.data = ser_rx.data;
    next_ser_tx = rf_rx; // see (RQ16)
    next_ser_tx.valid = rf_rx.valid && (op_mode == packetizer_pkg::MODE_RX || rx_take); // see (RQ2)
    next_src = rf_rx.valid ? rf_rx_src_addr : ser_tx_src_addr; // see (RQ13)
    next_framed = !transparent; // see (RQ11)
  end

  always_ff @(posedge clk) begin
    if (push && !full)
      buf_mem[wr_ptr] <= ser_rx.data;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= 16'h0000;
      overflow <= 1'b0;
      cmd_pending <= 1'b0;
      flushing <= 1'b0;
      op_mode <= packetizer_pkg::MODE_IDLE;
      rf_tx <= '0;
      api_rx <= '0;
      cmd_rx <= '0;
      ser_tx <= '0;
      ser_tx_src_addr <= 32'h0000_0000;
      ser_tx_framed <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      overflow <= next_overflow;
      cmd_pending <= next_cmd_pending;
      flushing <= next_flushing;
      op_mode <= next_op_mode;
      rf_tx <= next_rf_tx;
      api_rx <= next_api_rx;
      cmd_rx <= next_cmd_rx;
      ser_tx <= next_ser_tx;
      ser_tx_src_addr <= next_src;
      ser_tx_framed <= next_framed;
    end
  end
endmodule : serial_packetizer_mode_control

// ==== bench/packetizer_props.sv ====
// Checker for the serial packetizer ports
`timescale 1ns/1ns
module packetizer_props (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic spi_port_select,
  input wire logic api_mode_select,
  input wire logic [7:0] idle_packetize_char_count,
  input wire logic [31:0] dest_addr,
  input wire packetizer_pkg::byte_beat_t ser_rx,
  input wire packetizer_pkg::rf_beat_t rf_tx,
  input wire packetizer_pkg::byte_beat_t api_rx,
  input wire packetizer_pkg::byte_beat_t cmd_rx,
  input wire packetizer_pkg::byte_beat_t rf_rx,
  input wire logic rf_rx_last,
  input wire logic [31:0] rf_rx_src_addr,
  input wire packetizer_pkg::byte_beat_t ser_tx,
  input wire logic [31:0] ser_tx_src_addr,
  input wire logic ser_tx_framed,
  input var packetizer_pkg::op_mode_t op_mode
);
  logic [19:0] quiet;
  logic [19:0] next_quiet;
  wire logic transp = !api_mode_select && !spi_port_select;
  always_comb begin
    next_quiet = ser_rx.valid ? 20'h00000 : quiet + 20'h00001;
  end
  always_ff @(posedge clk) begin
    quiet <= sys_rst ? 20'h00000 : next_quiet;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence byte_in;
    ser_rx.valid && transp && idle_packetize_char_count == 8'h00 &&
      op_mode == packetizer_pkg::MODE_IDLE;
  endsequence
  sequence rx_byte;
    rf_rx.valid && op_mode == packetizer_pkg::MODE_RX;
  endsequence
  zero_flush_a: assert property (byte_in |-> ##[1:4] rf_tx.valid)
    else $error("immediate packetize missing");
  min_idle_a: assert property ($rose(op_mode == packetizer_pkg::MODE_TX_FLUSH) &&
    idle_packetize_char_count != 8'h00 && quiet > 20'h00008 |-> quiet >= 20'h003E8)
    else $error("idle flush too early");
  cmd_fwd_a: assert property (ser_rx.valid && op_mode == packetizer_pkg::MODE_CMD
    |=> cmd_rx.valid && cmd_rx.data == $past(ser_rx.data)) else $error("command byte lost");
  api_copy_a: assert property (ser_rx.valid && !transp
    |=> api_rx.valid && api_rx.data == $past(ser_rx.data)) else $error("framed byte lost");
  framed_flag_a: assert property (1 |=> ser_tx_framed == $past(!transp))
    else $error("framed flag wrong");
  spi_no_cmd_a: assert property (spi_port_select && op_mode != packetizer_pkg::MODE_CMD
    |=> op_mode != packetizer_pkg::MODE_CMD) else $error("command mode on spi");
  dest_addr_a: assert property (rf_tx.valid |-> rf_tx.addr == dest_addr)
    else $error("wrong destination");
  src_addr_a: assert property (rf_rx.valid |=> ser_tx_src_addr == $past(rf_rx_src_addr))
    else $error("source address wrong");
  rx_fwd_a: assert property (rx_byte |=> ser_tx.valid && ser_tx.data == $past(rf_rx.data))
    else $error("rf byte not forwarded");
  rx_exit_a: assert property (rx_byte ##0 rf_rx_last |-> ##[1:2]
    op_mode == packetizer_pkg::MODE_IDLE) else $error("no return to idle");
endmodule : packetizer_props
bind serial_packetizer_mode_control packetizer_props i_packetizer_props (.clk, .sys_rst,
  .spi_port_select, .api_mode_select, .idle_packetize_char_count, .dest_addr, .ser_rx,
  .rf_tx, .api_rx, .cmd_rx, .rf_rx, .rf_rx_last, .rf_rx_src_addr, .ser_tx,
  .ser_tx_src_addr, .ser_tx_framed, .op_mode);

// ==== bench/host_model.sv ====
// Host side model driving the serial receive path
`timescale 1ns/1ns
module host_model (
  // Clock
  input wire logic clk,
  // Serial toward the block
  output packetizer_pkg::byte_beat_t ser_rx,
  output logic serial_din_pin
);
  initial begin
    ser_rx = '0;
    serial_din_pin = 1'b1;
  end
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    #10;
    ser_rx <= {b, 1'b1};
    serial_din_pin <= ~serial_din_pin;
    @(posedge clk);
    #10;
    ser_rx <= {~b, 1'b0};
  endtask : send
  task automatic guard_seq(input logic [7:0] c, input int gap);
    repeat (gap) @(posedge clk);
    repeat (3) send(c);
    repeat (gap) @(posedge clk);
  endtask : guard_seq
endmodule : host_model

// ==== bench/tb_serial_packetizer_mode_control.sv ====
// Testbench for the serial packetizer
`timescale 1ns/1ns
module tb_serial_packetizer_mode_control;
  logic clk, sys_rst, spi, api, ex, rf_rx_last, serial_din_pin, ser_tx_framed;
  logic rdy, overflow;
  logic [7:0] cnt, cc;
  logic [15:0] ctim, gt;
  logic [31:0] src, dst, ser_tx_src_addr;
  packetizer_pkg::byte_beat_t ser_rx, rf_rx, ser_tx, api_rx, cmd_rx;
  packetizer_pkg::rf_beat_t rf_tx;
  packetizer_pkg::op_mode_t op_mode;
  logic [8:0] txq[$];
  logic [8:0] fq[$];
  logic [7:0] sq[$];
  int miscompares, comparisons, addr_errs;
  serial_packetizer_mode_control i_serial_packetizer_mode_control (.clk, .sys_rst,
    .spi_port_select(spi), .api_mode_select(api), .idle_packetize_char_count(cnt),
    .char_time_cycles(ctim), .guard_silence_time(gt), .command_sequence_char(cc),
    .dest_addr(dst), .cmd_exit(ex), .serial_din_pin, .ser_rx, .rf_tx,
    .rf_tx_ready(rdy), .api_rx, .cmd_rx, .rf_rx, .rf_rx_last,
    .rf_rx_src_addr(src), .ser_tx, .ser_tx_src_addr, .ser_tx_framed, .op_mode,
    .overflow);
  host_model i_host_model (.clk, .ser_rx, .serial_din_pin);
  always @(posedge clk) begin
    if (rf_tx.valid === 1'b1) txq.push_back({rf_tx.last, rf_tx.data});
    if (rf_tx.valid === 1'b1 && rf_tx.addr !== dst) addr_errs++;
    if (ser_tx.valid === 1'b1) sq.push_back(ser_tx.data);
    if (api_rx.valid === 1'b1) fq.push_back({1'b0, api_rx.data});
    if (cmd_rx.valid === 1'b1) fq.push_back({1'b1, cmd_rx.data});
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : step
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_zero;
    txq = {};
    i_host_model.send(8'h11);
    step(5);
    i_host_model.send(8'h22);
    step(5);
    check(txq.size(), 2);
    check(txq[1], 9'h122);
    $display("zero count done");
  endtask : t_zero
  task automatic t_idle(input logic [15:0] ct, input int lo, input int hi);
    cnt = 8'h02;
    ctim = ct;
    txq = {};
    i_host_model.send(8'h33);
    step(lo);
    check(txq.size(), 0);
    step(hi);
    check(txq.size(), 1);
    $display("idle count done");
  endtask : t_idle
  task automatic t_size;
    cnt = 8'hFF;
    rdy = 1'b0;
    dst = 32'h12345678;
    txq = {};
    for (int i = 0; i < 1024; i++) i_host_model.send(i[7:0]);
    step(2);
    check(op_mode, packetizer_pkg::MODE_TX_FLUSH);
    for (int i = 1024; i < 2049; i++) i_host_model.send(i[7:0]);
    check(overflow, 1'b1);
    rdy = 1'b1;
    step(2200);
    check(txq.size(), 2048);
    check(txq[2047], 9'h1FF);
    check(addr_errs, 0);
    $display("size trigger done");
  endtask : t_size
  task automatic t_cmd;
    txq = {};
    fq = {};
    cc = 8'h2D;
    i_host_model.send(8'h41);
    i_host_model.guard_seq(cc, 11000);
    step(20);
    check(txq[0], 9'h041);
    check(txq[3], 9'h12D);
    check(op_mode, packetizer_pkg::MODE_CMD);
    i_host_model.send(8'h42);
    step(5);
    check(txq.size(), 4);
    check(fq.size(), 1);
    check(fq[0], 9'h142);
    ex = 1'b1;
    step(1);
    ex = 1'b0;
    step(2);
    check(op_mode, packetizer_pkg::MODE_IDLE);
    $display("command entry done");
  endtask : t_cmd
  task automatic t_rx;
    sq = {};
    for (int i = 0; i < 3; i++) begin
      rf_rx = {8'h50 + i[7:0], 1'b1};
      rf_rx_last = (i == 2);
      step(1);
    end
    rf_rx = {8'hAD, 1'b0};
    rf_rx_last = 1'b0;
    step(5);
    check(sq.size(), 3);
    check(sq[0], 8'h50);
    check(sq[2], 8'h52);
    check(ser_tx_src_addr, src);
    $display("rf receive done");
  endtask : t_rx
  task automatic t_api;
    txq = {};
    fq = {};
    api = 1'b1;
    i_host_model.send(8'h7E);
    step(5);
    check(ser_tx_framed, 1'b1);
    api = 1'b0;
    spi = 1'b1;
    i_host_model.send(8'h7E);
    step(5);
    check(txq.size(), 0);
    check(ser_tx_framed, 1'b1);
    check(fq.size(), 2);
    check(fq[1], 9'h07E);
    spi = 1'b0;
    $display("framed mode done");
  endtask : t_api
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    final_report;
  end
  initial begin
    sys_rst = 1'b1;
    {spi, api, ex, rf_rx_last, rf_rx} = '0;
    cnt = 8'h00;
    ctim = 16'h000A;
    gt = 16'h0001;
    src = 32'h00005A01;
    rdy = 1'b1;
    cc = 8'h2B;
    dst = 32'h0000C0DE;
    repeat (5) @(posedge clk);
    #10;
    sys_rst = 1'b0;
    t_zero;
    t_idle(16'h000A, 900, 200);
    t_idle(16'h03E8, 1900, 300);
    t_size;
    t_cmd;
    t_rx;
    t_api;
    final_report;
  end
endmodule : tb_serial_packetizer_mode_control
